// ### design/scss_bank.v
// Purpose: status flags and run start/stop triggers for 3 units x 2 channels
// Assumes: channel events are one-cycle pulses from logic on CLK_IN
// Notes:   registers sit on an APB slave that answers with zero wait states
`timescale 1ns/1ps
`include "scss_defines.vh"

// Contract
// R1: frame error on missing UART stop bit
// R2: frame clear bit writing one clears
// R3: parity error on UART parity mismatch
// R4: missing I2C acknowledge sets parity flag
// R5: parity clear bit writing one clears
// R6: overrun on unread data overwritten
// R7: overrun clear bit writing one clears
// R8: start trigger sets run enable, self-clears
// R9: start mid-transfer aborts, keeps flags
// R10: stop trigger clears run enable, self-clears
// R11: stop keeps flags and pin levels; stop here clears the buffer valid flag
// R12: software writes zero above channel bits
// R13: triggers and status reset to zero
// R14: trigger registers always read zero
// R15: full and low-byte alias trigger writes
// R16: three units, two channels each
// R17: frame flag only on channel one
// R18: communicating flag set, cleared, trigger cleared
// R19: buffer write while valid raises overrun; here only while RECEIVE_ENABLE_IN is high and RX_READ_IN is low in that cycle
// R20: set wins over simultaneous clear
// R21: flags never cleared by status read
module scss_bank (
   input  wire        CLK_IN,
   input  wire        RST_N_IN,
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [7:0]  PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output reg         PREADY_OUT,
   output reg         PSLVERR_OUT,
   input  wire [5:0]  COMM_BEGIN_IN,
   input  wire [5:0]  COMM_END_IN,
   input  wire [5:0]  STOP_BIT_MISSING_IN,
   input  wire [5:0]  PARITY_MISMATCH_IN,
   input  wire [5:0]  ACK_MISSING_IN,
   input  wire [5:0]  RX_WORD_IN,
   input  wire [5:0]  RX_READ_IN,
   input  wire [5:0]  TX_WRITE_IN,
   input  wire [5:0]  RECEIVE_ENABLE_IN,
   output reg  [5:0]  RUN_ENABLE_OUT,
   output reg  [5:0]  ABORT_OUT,
   output reg  [5:0]  COMMUNICATING_OUT
);

   // bus decode
   wire        acc   = PSEL_IN & PENABLE_IN;
   wire        wr    = acc & PWRITE_IN;
   wire [1:0]  unit  = PADDR_IN[6:5];
   wire [4:0]  off   = PADDR_IN[4:0];
   // bit 7 must be low too, or 0x80 to 0xDF would alias onto units 0 to 2
   wire        in_unit = ~PADDR_IN[7] & (unit < 2'd3);

   reg  [5:0]  buffer_valid_flag;
   reg  [5:0]  frame_error_flag;
   reg  [5:0]  parity_error_flag;
   reg  [5:0]  overrun_flag;

   // per-channel clear and trigger strobes, decoded from the write
   reg  [5:0]  clr_frm;
   reg  [5:0]  clr_par;
   reg  [5:0]  clr_ovr;
   reg  [5:0]  start_trigger_bit;
   reg  [5:0]  stop_trigger_bit;
   integer     u;
   always @* begin
      clr_frm = 6'h00;
      clr_par = 6'h00;
      clr_ovr = 6'h00;
      start_trigger_bit = 6'h00;
      stop_trigger_bit  = 6'h00;
      for (u = 0; u < `SCSS_NUM_UNITS; u = u + 1) begin
         if (wr && in_unit && unit == u[1:0]) begin
            case (off)
               `SCSS_OFF_CLEAR0: begin
                  clr_par[2*u] = PWDATA_IN[`SCSS_BIT_PAR];           // see R5
                  clr_ovr[2*u] = PWDATA_IN[`SCSS_BIT_OVR];           // see R7
               end
               `SCSS_OFF_CLEAR1: begin
                  clr_frm[2*u+1] = PWDATA_IN[`SCSS_BIT_FRM];         // see R2, R17
                  clr_par[2*u+1] = PWDATA_IN[`SCSS_BIT_PAR];         // see R5
                  clr_ovr[2*u+1] = PWDATA_IN[`SCSS_BIT_OVR];         // see R7
               end
               // 32-bit word and byte alias carry the same two bits
               `SCSS_OFF_START, `SCSS_OFF_START_LO: begin
                  start_trigger_bit[2*u]   = PWDATA_IN[0];           // see R15
                  start_trigger_bit[2*u+1] = PWDATA_IN[1];
               end
               `SCSS_OFF_STOP, `SCSS_OFF_STOP_LO: begin
                  stop_trigger_bit[2*u]   = PWDATA_IN[0];            // see R15
                  stop_trigger_bit[2*u+1] = PWDATA_IN[1];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // per-channel state; triggers act in the write cycle, so they read zero
   genvar c;
   generate
      for (c = 0; c < `SCSS_NUM_CH; c = c + 1) begin : g_ch            // see R16
         always @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
               RUN_ENABLE_OUT[c]    <= 1'b0;                          // see R13
               COMMUNICATING_OUT[c] <= 1'b0;
               ABORT_OUT[c]         <= 1'b0;
               buffer_valid_flag[c] <= 1'b0;
               frame_error_flag[c]  <= 1'b0;
               parity_error_flag[c] <= 1'b0;
               overrun_flag[c]      <= 1'b0;
            end else begin
               // start wins over stop if both written at once
               if (start_trigger_bit[c])
                  RUN_ENABLE_OUT[c] <= 1'b1;                          // see R8
               else if (stop_trigger_bit[c])
                  RUN_ENABLE_OUT[c] <= 1'b0;                          // see R10
               // start during a transfer aborts it back to standby
               ABORT_OUT[c] <= start_trigger_bit[c] & COMMUNICATING_OUT[c]; // see R9
               if (start_trigger_bit[c] | stop_trigger_bit[c])
                  COMMUNICATING_OUT[c] <= 1'b0;                       // see R18
               else if (COMM_BEGIN_IN[c] & RUN_ENABLE_OUT[c])
                  COMMUNICATING_OUT[c] <= 1'b1;                       // see R18
               else if (COMM_END_IN[c])
                  COMMUNICATING_OUT[c] <= 1'b0;
               // buffer valid: set by a received word or a transmit write, cleared by a read or a stop trigger
               if (RX_WORD_IN[c] | TX_WRITE_IN[c])
                  buffer_valid_flag[c] <= 1'b1;
               else if (RX_READ_IN[c] | stop_trigger_bit[c])
                  buffer_valid_flag[c] <= 1'b0;
               // error flags: set beats clear, triggers leave them alone
               if (c % 2 == 1) begin
                  if (STOP_BIT_MISSING_IN[c])
                     frame_error_flag[c] <= 1'b1;                     // see R1, R20
                  else if (clr_frm[c])
                     frame_error_flag[c] <= 1'b0;                     // see R2, R11
               end
               if (PARITY_MISMATCH_IN[c] | ACK_MISSING_IN[c])
                  parity_error_flag[c] <= 1'b1;                       // see R3, R4, R20
               else if (clr_par[c])
                  parity_error_flag[c] <= 1'b0;                       // see R5, R9
               if (RECEIVE_ENABLE_IN[c] & buffer_valid_flag[c] & ~RX_READ_IN[c]
                   & (RX_WORD_IN[c] | TX_WRITE_IN[c]))
                  overrun_flag[c] <= 1'b1;                            // see R6, R19, R20
               else if (clr_ovr[c])
                  overrun_flag[c] <= 1'b0;                            // see R7, R11
            end
         end
      end
   endgenerate

   // status word of one channel; reads have no side effect
   function [15:0] status_word;
      input integer ch;
      begin
         status_word = `SCSS_STATUS_RESET;
         status_word[`SCSS_BIT_COMM] = COMMUNICATING_OUT[ch];
         status_word[`SCSS_BIT_BUF]  = buffer_valid_flag[ch];
         status_word[`SCSS_BIT_FRM]  = frame_error_flag[ch] & (ch % 2 == 1); // see R17
         status_word[`SCSS_BIT_PAR]  = parity_error_flag[ch];
         status_word[`SCSS_BIT_OVR]  = overrun_flag[ch];              // see R21
      end
   endfunction

   // read mux; triggers and clear registers read zero
   reg [31:0] next_rdata;
   reg        next_err;
   always @* begin
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      if (PADDR_IN == `SCSS_OFF_RUN)
         next_rdata = {26'h0000000, RUN_ENABLE_OUT};
      else if (in_unit) begin
         case (off)
            `SCSS_OFF_STATUS0:
               next_rdata = {16'h0000, status_word({29'h0, unit, 1'b0})};
            `SCSS_OFF_STATUS1:
               next_rdata = {16'h0000, status_word({29'h0, unit, 1'b1})};
            `SCSS_OFF_CLEAR0, `SCSS_OFF_CLEAR1, `SCSS_OFF_START, `SCSS_OFF_START_LO,
            `SCSS_OFF_STOP, `SCSS_OFF_STOP_LO:
               next_rdata = 32'h00000000;                             // see R14
            default:
               next_err = 1'b1;
         endcase
      end else
         next_err = 1'b1;
   end

   // zero-wait answer: pready high throughout the access phase
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         PRDATA_OUT  <= 32'h00000000;
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
         PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & next_err;
         if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN)
            PRDATA_OUT <= next_rdata;
      end
   end

endmodule // scss_bank

// ### include/scss_defines.vh
// Purpose: constants for the serial channel status and start/stop bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   three units of two channels each
`ifndef SCSS_DEFINES_VH
`define SCSS_DEFINES_VH
`define SCSS_NUM_UNITS      3
`define SCSS_NUM_CH         6
// per-unit block of registers, stride 0x20
`define SCSS_UNIT_STRIDE    8'h20
`define SCSS_OFF_STATUS0    8'h00
`define SCSS_OFF_STATUS1    8'h04
`define SCSS_OFF_CLEAR0     8'h08
`define SCSS_OFF_CLEAR1     8'h0C
`define SCSS_OFF_START      8'h10
`define SCSS_OFF_START_LO   8'h14
`define SCSS_OFF_STOP       8'h18
`define SCSS_OFF_STOP_LO    8'h1C
// run enable readback, one word for all channels
`define SCSS_OFF_RUN        8'h60
// status and clear bit positions
`define SCSS_BIT_OVR        0
`define SCSS_BIT_PAR        1
`define SCSS_BIT_FRM        2
`define SCSS_BIT_BUF        5
`define SCSS_BIT_COMM       6
`define SCSS_STATUS_RESET   16'h0000
`define SCSS_TRIG_RESET     2'h0
`endif

// ### test/scss_bank_chk.sv
// Purpose: port assertions for the status and start/stop bank
// Assumes: zero wait apb, channel index 2*unit+channel
// Notes:   bound to scss_bank below
`timescale 1ns/1ps
module scss_chk (
   input wire logic        CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [7:0]  PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic [5:0]  COMM_BEGIN_IN,
   input wire logic [5:0]  RUN_ENABLE_OUT,
   input wire logic [5:0]  ABORT_OUT,
   input wire logic [5:0]  COMMUNICATING_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // decoded trigger writes; only bits 1:0 of the data count
   wire       acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
   wire       w   = acc & (PADDR_IN[7:5] < 3'h3);
   wire       rd  = w & ~PWRITE_IN;
   wire [5:0] wb  = {3{PWDATA_IN[1:0]}} & (6'h03 << {PADDR_IN[6:5], 1'b0});
   wire [5:0] st  = (w & PWRITE_IN & PADDR_IN[4:3] == 2'h2) ? wb : 6'h00;
   wire [5:0] sp  = (w & PWRITE_IN & PADDR_IN[4:3] == 2'h3) ? wb : 6'h00;
   wire [5:0] trg = (st | sp) & ~COMM_BEGIN_IN;
   start_sets_a: assert property (st != 6'h00 |=> (RUN_ENABLE_OUT & $past(st)) == $past(st))
      else $error("start missed");
   stop_clears_a: assert property (st == 6'h00 && sp != 6'h00 |=> (RUN_ENABLE_OUT & $past(sp)) == 6'h00)
      else $error("stop missed");
   abort_pulse_a: assert property (1'b1 |=> ABORT_OUT == $past(st & COMMUNICATING_OUT))
      else $error("abort wrong");
   comm_drop_a: assert property (trg != 6'h00 |=> (COMMUNICATING_OUT & $past(trg)) == 6'h00)
      else $error("comm kept");
   trig_read_a: assert property (rd && PADDR_IN[4] |-> PRDATA_OUT == 32'h00000000)
      else $error("trigger read");
   frame_ch0_a: assert property (rd && PADDR_IN[4:2] == 3'h0 |-> PRDATA_OUT[2] == 1'b0)
      else $error("frame on ch0");
   run_view_a: assert property (acc && !PWRITE_IN && PADDR_IN == 8'h60 |-> PRDATA_OUT[5:0] == RUN_ENABLE_OUT)
      else $error("run view");
   reset_zero_a: assert property ($rose(RST_N_IN) |-> RUN_ENABLE_OUT == 6'h00 && COMMUNICATING_OUT == 6'h00)
      else $error("reset value");
   cover property (st != 6'h00);
   cover property (ABORT_OUT != 6'h00);
   cover property (sp != 6'h00);
endmodule // scss_chk
bind scss_bank scss_chk i_scss_chk (.CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
   .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .COMM_BEGIN_IN, .RUN_ENABLE_OUT,
   .ABORT_OUT, .COMMUNICATING_OUT);

// ### test/scss_bank_test.sv
// Purpose: random and corner tests of the status and start/stop bank
// Assumes: zero wait apb, channel index 2*unit+channel
// Notes:   run enable is modelled, flags predicted per channel
`timescale 1ns/1ps
module scss_bank_test;
   `define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
      $display("ERROR %s expected %h seen %h", n, e, s); end end
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdata, prdata;
   logic [5:0]  ev [8], re = 6'h00, run_m = 6'h00, run, abort, comm;
   int          failures = 0, checked = 0, cyc = 0;
   scss_bank i_scss_bank (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COMM_BEGIN_IN(ev[0]), .COMM_END_IN(ev[1]),
      .STOP_BIT_MISSING_IN(ev[2]), .PARITY_MISMATCH_IN(ev[3]), .ACK_MISSING_IN(ev[4]),
      .RX_WORD_IN(ev[5]), .RX_READ_IN(ev[6]), .TX_WRITE_IN(ev[7]), .RECEIVE_ENABLE_IN(re),
      .RUN_ENABLE_OUT(run), .ABORT_OUT(abort), .COMMUNICATING_OUT(comm));
   initial forever #5 clk = ~clk;
   // hang guard, well above the expected run
   always @(posedge clk) if (++cyc == 8000) begin failures++; test_done; end
   task automatic test_done;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // request held until pready is sampled high
   task automatic xfer(input [7:0] a, input w, input [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input string n, input [7:0] a, input [31:0] e);
      xfer(a, 1'b0, 32'h0);
      `CHK(n, e, rdata)
   endtask
   task automatic pulse(input int k, input int c);
      @(posedge clk);
      ev[k][c] <= 1'b1;
      @(posedge clk);
      ev[k] <= 6'h00;
      @(negedge clk);
   endtask
   // flags left after overrun, parity and frame events; frame exists on odd channels only
   function automatic [31:0] flags(int c, logic [2:0] m);
      return {29'h0, ((c % 2) ? 3'h7 : 3'h3) & ~m};
   endfunction
   function automatic [7:0] taddr(int c, bit stop, bit lo);
      return 8'((c / 2) * 32 + (stop ? 24 : 16) + lo * 4);
   endfunction
   initial begin
      int c, s;
      logic [7:0] a;
      logic [2:0] m;
      foreach (ev[i]) ev[i] = 6'h00;
      c = $urandom(32'h0C16);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (c = 0; c < 6; c++) rd("status", 8'((c / 2) * 32 + (c % 2) * 4), 32'h0);
      rd("run", 8'h60, 32'h0);
      re <= 6'h3F;
      // random start and stop traffic over full and byte alias addresses
      repeat (40) begin
         c = $urandom % 6;
         s = $urandom % 2;
         xfer(taddr(c, s, $urandom % 2), 1'b1, 32'(1 << (c % 2)));
         run_m = s ? run_m & ~(6'h01 << c) : run_m | (6'h01 << c);
         rd("run", 8'h60, {26'h0, run_m});
         rd("trig", taddr(c, s, 1'b0), 32'h0);
      end
      rd("unmapped", 8'h80, 32'h0);
      `CHK("slverr", 1'b1, err)
      // per channel: raise flags, abort, stop, then clear in random mix
      for (c = 0; c < 6; c++) begin
         a = 8'((c / 2) * 32 + (c % 2) * 4);
         xfer(taddr(c, 0, 0), 1'b1, 32'(1 << (c % 2)));
         pulse(3, c);
         pulse(2, c);
         pulse(5, c);
         pulse(7, c);
         pulse(0, c);
         `CHK("comm", 1'b1, comm[c])
         rd("flags", a, 32'h60 | flags(c, 3'h0));
         xfer(taddr(c, 0, 1), 1'b1, 32'(1 << (c % 2)));
         rd("kept", a, 32'h20 | flags(c, 3'h0));
         `CHK("comm", 1'b0, comm[c])
         pulse(6, c);
         xfer(taddr(c, 1, c % 2), 1'b1, 32'(1 << (c % 2)));
         rd("stopped", a, flags(c, 3'h0));
         m = $urandom;
         xfer(a + 8'h08, 1'b1, {29'h0, m});
         rd("cleared", a, flags(c, m));
         // missing ack lands in the same cycle as a parity clear write
         fork
            xfer(a + 8'h08, 1'b1, 32'h2);
            begin
               @(posedge clk);
               pulse(4, c);
            end
         join
         rd("ack", a, flags(c, m) | 32'h2);
      end
      test_done;
   end
endmodule // scss_bank_test
